//--- fia_pkg.sv
// Constants, field positions and types shared by the flash indirect access engine
package fia_pkg;
  // Register offsets inside the flash space
  localparam logic [15:0] FIA_OFS_ADDRESS_POINTER = 16'h0000;
  localparam logic [15:0] FIA_OFS_DATA_PORT = 16'h0004;
  localparam logic [15:0] FIA_OFS_IDENTITY = 16'h0008;
  localparam logic [15:0] FIA_OFS_SECTOR_ERASE = 16'h000c;
  localparam logic [1:0] FIA_SEL_ADDRESS_POINTER = 2'h0;
  localparam logic [1:0] FIA_SEL_DATA_PORT = 2'h1;
  localparam logic [1:0] FIA_SEL_IDENTITY = 2'h2;
  localparam logic [1:0] FIA_SEL_SECTOR_ERASE = 2'h3;
  // Command word field positions
  localparam int FIA_CMD_WRITE_BIT = 15;
  localparam int FIA_CMD_ADDR_BIT = 14;
  localparam int FIA_CMD_INFO_BIT = 13;
  localparam int FIA_CMD_SPACE_LSB = 10;
  localparam int FIA_CMD_SIZE_LSB = 8;
  localparam int FIA_CMD_INC_BIT = 7;
  // Accepted field values
  localparam logic [2:0] FIA_SPACE_FLASH = 3'h3;
  localparam logic [1:0] FIA_SIZE_32 = 2'h2;
  localparam logic [6:0] FIA_COUNT_ZERO = 7'h00;
  localparam logic [6:0] FIA_COUNT_LAST = 7'h01;
  // Write-unlock key, pointer step and reset values
  localparam logic [15:0] FIA_UNLOCK_KEY = 16'h5a03;
  localparam logic [31:0] FIA_POINTER_STEP = 32'h0000_0004;
  localparam logic [15:0] FIA_ELEMENT_STEP = 16'h0004;
  localparam logic [31:0] FIA_POINTER_RESET = 32'h0000_0000;
  localparam logic [1:0] FIA_LAST_BYTE = 2'h3;

  // Operations requested from the flash controller
  typedef enum logic [1:0] {
    FIA_OP_READ = 2'h0,
    FIA_OP_PROGRAM = 2'h1,
    FIA_OP_ERASE = 2'h2,
    FIA_OP_IDENTITY = 2'h3
  } fia_op_t;

  // Command parser states, one-hot
  typedef enum logic [8:0] {
    FIA_S_IDLE = 9'h001,
    FIA_S_CMD_HI = 9'h002,
    FIA_S_ADR_LO = 9'h004,
    FIA_S_ADR_HI = 9'h008,
    FIA_S_DATA = 9'h010,
    FIA_S_EXEC = 9'h020,
    FIA_S_WAIT = 9'h040,
    FIA_S_RESP = 9'h080,
    FIA_S_DRAIN = 9'h100
  } fia_state_t;
endpackage : fia_pkg

//--- fia_skid2.sv
// Two-entry buffer with valid and ready on both sides
module fia_skid2
  import fia_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [WIDTH-1:0] second;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  // Occupancy after this cycle
  assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  // Head entry feeds the output, second entry catches a stalled word
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cnt <= 2'h0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
      second <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      in_ready_out <= (next_cnt != 2'h2);
      out_valid_out <= (next_cnt != 2'h0);
      if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop)))
        out_data_out <= in_data_in;
      else if (pop)
        out_data_out <= second;
      if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop)))
        second <= in_data_in;
    end
  end
endmodule : fia_skid2

//--- fia_flash_indirect.sv
// Flash indirect access engine: command parser, page buffer and flash sequencing
//
// Behaviour
// - Flash space accepts only 32-bit elements.
// - Flash reached only via pointer and data port.
// - Read commands: 0x4E with address, 0x0E without.
// - Write commands: 0xCE with address, 0x8E without.
// - Four registers at offsets 0, 4, 8, C.
// - Identity register read-only; writes ignored.
// - Erase write erases sector at pointer.
// - Data port access advances pointer by four.
// - Write data limited to one page.
// - Pointer, data read, identity, erase start program.
// - Pointer read answers after program completes.
// - Program and erase need unlock key 5A03.
// - Unlock cleared at end of every packet.
// - Count gives number of 32-bit doublewords.
// - Data and addresses travel low byte first.
// - Bit 0x80 increments address; low bits count.
// - Command word: flags, space, size, increment, count.
// - Zero count is an error.
// - Address-follows flag loads the space pointer.
module fia_flash_indirect
  import fia_pkg::*;
#(
  parameter int PAGE_WORDS = 64,
  parameter int IDX_W = $clog2(PAGE_WORDS)
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic rx_end_in,
  input wire logic unlock_wr_in,
  input wire logic [15:0] unlock_data_in,
  output logic unlock_active_out,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic flash_req_out,
  output logic [1:0] flash_op_out,
  output logic [31:0] flash_addr_out,
  output logic [IDX_W:0] flash_len_out,
  input wire logic flash_done_in,
  input wire logic [31:0] flash_rdata_in,
  input wire logic [IDX_W-1:0] flash_buf_idx_in,
  output logic [31:0] flash_buf_data_out,
  output logic cmd_error_out
);
  localparam logic [IDX_W:0] PAGE_FULL = (IDX_W+1)'(PAGE_WORDS);

  fia_state_t state;
  fia_state_t next_state;
  fia_state_t fin_state;
  logic [7:0] cmd_lo;
  logic cmd_wr;
  logic cmd_inc;
  logic [6:0] count;
  logic [15:0] space_addr;
  logic [31:0] pointer;
  logic [31:0] wdata;
  logic [31:0] rsp;
  logic [1:0] byte_idx;
  fia_op_t op;
  logic [IDX_W:0] buf_count;
  logic [31:0] page_buf [PAGE_WORDS];
  logic [31:0] prog_addr;
  logic end_pend;
  logic resp_ready;

  // Byte handshakes on the receive and answer paths
  wire rx_take = rx_valid_in & rx_ready_out;
  wire resp_push = (state == FIA_S_RESP) & resp_ready;
  wire last_byte = (byte_idx == FIA_LAST_BYTE);
  wire [15:0] cmd_word = {rx_data_in, cmd_lo};

  // Command word checks: only 32-bit, flash space, memory area, non-zero count
  wire cmd_space_ok = (cmd_word[FIA_CMD_SPACE_LSB +: 3] == FIA_SPACE_FLASH);
  wire cmd_size_ok = (cmd_word[FIA_CMD_SIZE_LSB +: 2] == FIA_SIZE_32);
  wire cmd_count_ok = (cmd_word[6:0] != FIA_COUNT_ZERO);
  wire cmd_ok = cmd_space_ok & cmd_size_ok & cmd_count_ok & ~cmd_word[FIA_CMD_INFO_BIT];
  wire cmd_has_addr = cmd_word[FIA_CMD_ADDR_BIT];

  // Register decode of the current element address
  wire mapped = (space_addr[15:4] == 12'h000) && (space_addr[1:0] == 2'h0);
  wire [1:0] reg_sel = space_addr[3:2];
  wire sel_ptr = mapped & (reg_sel == FIA_SEL_ADDRESS_POINTER);
  wire sel_data = mapped & (reg_sel == FIA_SEL_DATA_PORT);
  wire sel_id = mapped & (reg_sel == FIA_SEL_IDENTITY);
  wire sel_erase = mapped & (reg_sel == FIA_SEL_SECTOR_ERASE);

  // Accesses that start programming of the buffered page
  wire prog_trigger = sel_ptr | (~cmd_wr & (sel_data | sel_id)) | (cmd_wr & sel_erase);
  wire need_prog = prog_trigger & (buf_count != '0) & unlock_active_out;

  // Element actions decided in the execute state
  wire ex_read_flash = ~cmd_wr & sel_data;
  wire ex_read_id = ~cmd_wr & sel_id;
  wire ex_erase = cmd_wr & sel_erase & unlock_active_out;
  wire ex_store = cmd_wr & sel_data & unlock_active_out & (buf_count != PAGE_FULL);
  wire ex_flash = need_prog | ex_read_flash | ex_read_id | ex_erase;
  wire ex_answer = ~cmd_wr & ~ex_flash;

  // Element address advance and the state after an element completes
  wire [15:0] next_space_addr = cmd_inc ? space_addr + FIA_ELEMENT_STEP : space_addr;
  assign fin_state = (count == FIA_COUNT_LAST) ? FIA_S_IDLE : (cmd_wr ? FIA_S_DATA : FIA_S_EXEC);

  // Next parser state
  always_comb
  begin
    next_state = state;
    case (state)
      FIA_S_IDLE:
        if (rx_take)
          next_state = FIA_S_CMD_HI;
      FIA_S_CMD_HI:
        if (rx_take)
        begin
          if (!cmd_ok)
            next_state = FIA_S_DRAIN;
          else if (cmd_has_addr)
            next_state = FIA_S_ADR_LO;
          else if (cmd_word[FIA_CMD_WRITE_BIT])
            next_state = FIA_S_DATA;
          else
            next_state = FIA_S_EXEC;
        end
      FIA_S_ADR_LO:
        if (rx_take)
          next_state = FIA_S_ADR_HI;
      FIA_S_ADR_HI:
        if (rx_take)
          next_state = cmd_wr ? FIA_S_DATA : FIA_S_EXEC;
      FIA_S_DATA:
        if (rx_take && last_byte)
          next_state = FIA_S_EXEC;
      FIA_S_EXEC:
        if (ex_flash)
          next_state = FIA_S_WAIT;
        else if (ex_answer)
          next_state = FIA_S_RESP;
        else
          next_state = fin_state;
      FIA_S_WAIT:
        if (flash_done_in)
        begin
          case (op)
            FIA_OP_PROGRAM: next_state = FIA_S_EXEC;
            FIA_OP_ERASE: next_state = fin_state;
            default: next_state = FIA_S_RESP;
          endcase
        end
      FIA_S_RESP:
        if (resp_push && last_byte)
          next_state = fin_state;
      FIA_S_DRAIN:
        if (rx_end_in || end_pend)
          next_state = FIA_S_IDLE;
      default:
        next_state = FIA_S_IDLE;
    endcase
  end

  // Receive readiness follows the state that the parser enters
  wire next_receiving = (next_state == FIA_S_IDLE) || (next_state == FIA_S_CMD_HI) ||
    (next_state == FIA_S_ADR_LO) || (next_state == FIA_S_ADR_HI) ||
    (next_state == FIA_S_DATA) || (next_state == FIA_S_DRAIN);
  wire end_apply = (state == FIA_S_IDLE) & end_pend;

  // State, readiness and packet-end bookkeeping
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state <= FIA_S_IDLE;
      rx_ready_out <= 1'b0;
      end_pend <= 1'b0;
      unlock_active_out <= 1'b0;
      cmd_error_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rx_ready_out <= next_receiving;
      end_pend <= rx_end_in | (end_pend & ~end_apply);
      cmd_error_out <= (state == FIA_S_CMD_HI) & rx_take & ~cmd_ok;
      if (unlock_wr_in)
        unlock_active_out <= (unlock_data_in == FIA_UNLOCK_KEY);
      else if (end_apply)
        unlock_active_out <= 1'b0;
    end
  end

  // Command fields and element address, bytes taken low first
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cmd_lo <= 8'h00;
      cmd_wr <= 1'b0;
      cmd_inc <= 1'b0;
      count <= FIA_COUNT_ZERO;
      space_addr <= 16'h0000;
      byte_idx <= 2'h0;
      wdata <= 32'h0000_0000;
    end
    else
    begin
      if (state == FIA_S_IDLE && rx_take)
        cmd_lo <= rx_data_in;
      if (state == FIA_S_CMD_HI && rx_take)
      begin
        cmd_wr <= cmd_word[FIA_CMD_WRITE_BIT];
        cmd_inc <= cmd_word[FIA_CMD_INC_BIT];
        count <= cmd_word[6:0];
      end
      if (state == FIA_S_ADR_LO && rx_take)
        space_addr[7:0] <= rx_data_in;
      if (state == FIA_S_ADR_HI && rx_take)
        space_addr[15:8] <= rx_data_in;
      if (state == FIA_S_DATA && rx_take)
      begin
        wdata[8*byte_idx +: 8] <= rx_data_in;
        byte_idx <= byte_idx + 2'h1;
      end
      if (resp_push)
        byte_idx <= byte_idx + 2'h1;
      // A finished page program resumes the same element, so it must not advance it
      if (next_state != state && (next_state == fin_state) &&
          !(state == FIA_S_WAIT && op == FIA_OP_PROGRAM) &&
          (state == FIA_S_EXEC || state == FIA_S_WAIT || state == FIA_S_RESP))
      begin
        space_addr <= next_space_addr;
        count <= count - FIA_COUNT_LAST;
      end
    end
  end

  // Flash pointer, answer word and flash requests
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pointer <= FIA_POINTER_RESET;
      rsp <= 32'h0000_0000;
      op <= FIA_OP_READ;
      flash_req_out <= 1'b0;
      flash_op_out <= FIA_OP_READ;
      flash_addr_out <= 32'h0000_0000;
      flash_len_out <= '0;
    end
    else
    begin
      flash_req_out <= 1'b0;
      if (state == FIA_S_EXEC)
      begin
        if (need_prog)
        begin
          op <= FIA_OP_PROGRAM;
          flash_req_out <= 1'b1;
          flash_op_out <= FIA_OP_PROGRAM;
          flash_addr_out <= prog_addr;
          flash_len_out <= buf_count;
        end
        else if (ex_read_flash || ex_read_id || ex_erase)
        begin
          op <= ex_read_flash ? FIA_OP_READ : (ex_read_id ? FIA_OP_IDENTITY : FIA_OP_ERASE);
          flash_req_out <= 1'b1;
          flash_op_out <= ex_read_flash ? FIA_OP_READ : (ex_read_id ? FIA_OP_IDENTITY : FIA_OP_ERASE);
          flash_addr_out <= pointer;
          flash_len_out <= (IDX_W+1)'(1);
        end
        else if (cmd_wr && sel_ptr)
          pointer <= wdata;
        else if (cmd_wr && sel_data)
          pointer <= pointer + FIA_POINTER_STEP;
        else if (ex_answer)
          rsp <= sel_ptr ? pointer : 32'h0000_0000;
      end
      if (state == FIA_S_WAIT && flash_done_in)
      begin
        if (op == FIA_OP_READ || op == FIA_OP_IDENTITY)
          rsp <= flash_rdata_in;
        if (op == FIA_OP_READ)
          pointer <= pointer + FIA_POINTER_STEP;
      end
    end
  end

  // Page buffer fill, cleared by a finished program or by packet end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      buf_count <= '0;
      prog_addr <= 32'h0000_0000;
    end
    else if (state == FIA_S_WAIT && flash_done_in && op == FIA_OP_PROGRAM)
      buf_count <= '0;
    else if (end_apply)
      buf_count <= '0;
    else if (state == FIA_S_EXEC && !need_prog && ex_store)
    begin
      buf_count <= buf_count + (IDX_W+1)'(1);
      if (buf_count == '0)
        prog_addr <= pointer;
    end
  end

  // Page storage written by index, read back by the flash controller
  always_ff @(posedge ref_clk_in)
  begin
    if (state == FIA_S_EXEC && !need_prog && ex_store)
      page_buf[buf_count[IDX_W-1:0]] <= wdata;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      flash_buf_data_out <= 32'h0000_0000;
    else
      flash_buf_data_out <= page_buf[flash_buf_idx_in];
  end

  // Answer bytes go out low byte first through the two-entry buffer
  fia_skid2 #(
    .WIDTH(8)
  ) u_answer_buf (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(state == FIA_S_RESP),
    .in_ready_out(resp_ready),
    .in_data_in(rsp[8*byte_idx +: 8]),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_data_out)
  );
endmodule : fia_flash_indirect

//--- fia_checker.sv
// Port checks for the flash indirect access engine
module fia_chk
  import fia_pkg::*;
#(
  parameter int PAGE_WORDS = 64,
  parameter int IDX_W = $clog2(PAGE_WORDS)
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic rx_end_in,
  input wire logic unlock_wr_in,
  input wire logic [15:0] unlock_data_in,
  input wire logic unlock_active_out,
  input wire logic tx_valid_out,
  input wire logic flash_req_out,
  input wire logic [1:0] flash_op_out,
  input wire logic [31:0] flash_addr_out,
  input wire logic [IDX_W:0] flash_len_out,
  input wire logic flash_done_in
);
  logic busy;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // Marks a flash operation as outstanding until done
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in) busy <= 1'b0;
    else if (flash_req_out) busy <= 1'b1;
    else if (flash_done_in) busy <= 1'b0;
  end
  // Program or erase request, and completion of a fetch
  sequence s_nv;
    flash_req_out && flash_op_out inside {FIA_OP_PROGRAM, FIA_OP_ERASE};
  endsequence
  sequence s_rd;
    flash_done_in && busy && flash_op_out inside {FIA_OP_READ, FIA_OP_IDENTITY};
  endsequence
  property p_key; unlock_wr_in && unlock_data_in == 16'h5a03 |=> unlock_active_out; endproperty
  a_key: assert property (p_key) else $error("key did not unlock");
  property p_bad_key; unlock_wr_in && unlock_data_in != 16'h5a03 |=> !unlock_active_out; endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key unlocked");
  property p_locked; s_nv |-> unlock_active_out || $past(unlock_active_out); endproperty
  a_locked: assert property (p_locked) else $error("program or erase while locked");
  property p_len; flash_req_out && flash_op_out == FIA_OP_PROGRAM |-> flash_len_out inside {[1:PAGE_WORDS]}; endproperty
  a_len: assert property (p_len) else $error("page length out of range");
  property p_one; flash_req_out |-> !busy; endproperty
  a_one: assert property (p_one) else $error("request before completion");
  property p_answer; s_rd |-> ##[1:3] tx_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("no answer after fetch");
  property p_clear; rx_end_in |-> ##[0:200] (!unlock_active_out || unlock_wr_in); endproperty
  a_clear: assert property (p_clear) else $error("unlock kept after packet");
  property p_held; !flash_req_out |-> $stable(flash_op_out) && $stable(flash_addr_out); endproperty
  a_held: assert property (p_held) else $error("request fields moved");
endmodule : fia_chk

bind fia_flash_indirect fia_chk #(.PAGE_WORDS(PAGE_WORDS), .IDX_W(IDX_W)) fia_chk_inst (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .rx_end_in(rx_end_in), .unlock_wr_in(unlock_wr_in), .unlock_data_in(unlock_data_in),
  .unlock_active_out(unlock_active_out), .tx_valid_out(tx_valid_out), .flash_req_out(flash_req_out),
  .flash_op_out(flash_op_out), .flash_addr_out(flash_addr_out), .flash_len_out(flash_len_out),
  .flash_done_in(flash_done_in));

//--- fia_fm.sv
// Behavioural flash controller facing the engine
module fia_fm
  import fia_pkg::*;
#(
  parameter int IDX_W = 2,
  parameter logic [31:0] ID_VALUE = 32'h1357_2468 // Arbitrary identity value
)
(
  input wire logic ref_clk_in,
  input wire logic req_in,
  input wire logic [1:0] op_in,
  input wire logic [31:0] addr_in,
  input wire logic [IDX_W:0] len_in,
  input wire logic [31:0] buf_in,
  input wire logic slow_in,
  output logic done_out,
  output logic [31:0] rdata_out,
  output logic [IDX_W-1:0] idx_out
);
  logic [31:0] mem [logic [31:0]];
  int progs = 0;
  int erases = 0;
  logic [31:0] erase_at = '0;
  // Serves one request at a time, promptly or slowly
  initial
  begin
    done_out = 1'b0;
    rdata_out = '0;
    idx_out = '0;
    forever
    begin
      @(posedge ref_clk_in);
      if (req_in === 1'b1)
      begin
        repeat (slow_in ? 9 : 1) @(posedge ref_clk_in);
        if (op_in == FIA_OP_PROGRAM)
          for (int i = 0; i < len_in; i++)
          begin
            idx_out <= i[IDX_W-1:0];
            repeat (2) @(posedge ref_clk_in);
            mem[addr_in + 32'(4 * i)] = buf_in;
            progs++;
          end
        if (op_in == FIA_OP_ERASE)
        begin
          erases++;
          erase_at = addr_in;
        end
        rdata_out <= (op_in == FIA_OP_IDENTITY) ? ID_VALUE : mem.exists(addr_in) ? mem[addr_in] : 32'hffff_ffff;
        done_out <= 1'b1;
        @(posedge ref_clk_in);
        done_out <= 1'b0;
        rdata_out <= ~rdata_out;
      end
    end
  end
endmodule : fia_fm

//--- flash_indirect_access_tb_top.sv
// Self-checking bench for the flash indirect access engine
module flash_indirect_access_tb_top
  import fia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 4;
  localparam logic [31:0] ID_VAL = 32'h1357_2468; // Arbitrary identity value
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] rx_data_in = '0;
  logic rx_valid_in = 1'b0, rx_end_in = 1'b0, unlock_wr_in = 1'b0, tx_ready_in = 1'b1, slow = 1'b0;
  logic [15:0] unlock_data_in = '0;
  logic rx_ready_out, unlock_active_out, tx_valid_out, flash_req_out, flash_done_in, cmd_error_out;
  logic [7:0] tx_data_out;
  logic [1:0] flash_op_out, flash_buf_idx_in;
  logic [31:0] flash_addr_out, flash_buf_data_out, flash_rdata_in, ptr = '0, pend_at = '0, era = '0;
  logic [2:0] flash_len_out;
  logic [15:0] bad [4] = '{16'h4e00, 16'h4d01, 16'h4201, 16'h6e01};
  int num_errors = 0, compares = 0, eras = 0;
  logic [7:0] rq[$];
  logic [31:0] wq[$], pend[$];
  logic [31:0] emem [logic [31:0]];
  logic unl = 1'b0, err_seen = 1'b0;
  always #20 ref_clk_in = ~ref_clk_in;
  fia_flash_indirect #(.PAGE_WORDS(PW)) fia_flash_indirect_inst (.*);
  fia_fm #(.IDX_W(2), .ID_VALUE(ID_VAL)) fia_fm_inst (.ref_clk_in(ref_clk_in), .req_in(flash_req_out),
    .op_in(flash_op_out), .addr_in(flash_addr_out), .len_in(flash_len_out), .buf_in(flash_buf_data_out),
    .slow_in(slow), .done_out(flash_done_in), .rdata_out(flash_rdata_in), .idx_out(flash_buf_idx_in));
  // Collects answer bytes, stalls the answer side at random, notes errors
  always @(posedge ref_clk_in)
  begin
    if (tx_valid_out === 1'b1 && tx_ready_in) rq.push_back(tx_data_out);
    if (cmd_error_out === 1'b1) err_seen <= 1'b1;
    tx_ready_in <= ($urandom_range(3) != 0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic hang();
    num_errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    finish_test();
  endtask : hang
  task automatic put(input logic [7:0] b);
    rx_data_in <= b;
    rx_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    for (int n = 0; n < 400 && rx_ready_out !== 1'b1; n++) @(posedge ref_clk_in);
    if (rx_ready_out !== 1'b1) hang();
  endtask : put
  task automatic commit();
    foreach (pend[i]) emem[pend_at + 32'(4 * i)] = pend[i];
    pend.delete();
  endtask : commit
  // Sends one command, keeps the reference model and checks every answer
  task automatic xfer(input logic w, input logic [15:0] ofs, input int cnt, input logic a, input logic inc = 1'b0);
    logic [15:0] c;
    logic [31:0] d;
    logic [31:0] e;
    c = {w, a, 1'b0, FIA_SPACE_FLASH, FIA_SIZE_32, inc, 7'(cnt)};
    put(c[7:0]);
    put(c[15:8]);
    if (a)
    begin
      put(ofs[7:0]);
      put(ofs[15:8]);
    end
    // A read sends no more bytes, so the last header byte must not be offered again
    if (!w) rx_valid_in <= 1'b0;
    for (int i = 0; i < cnt; i++)
    begin
      e = '0;
      if (w) d = wq.pop_front();
      if (w) for (int j = 0; j < 4; j++) put(d[8*j+:8]);
      if (ofs == 16'h0 || w == (ofs == 16'hc)) commit();
      case (ofs)
        16'h0: if (w) ptr = d; else e = ptr;
        16'h4:
        begin
          if (w && unl && pend.size() < PW) pend_at = pend.size() ? pend_at : ptr;
          if (w && unl && pend.size() < PW) pend.push_back(d);
          e = emem.exists(ptr) ? emem[ptr] : 32'hffff_ffff;
          ptr += 4;
        end
        16'h8: e = ID_VAL;
        default: if (w && unl) {eras, era} = {eras + 1, ptr};
      endcase
      if (!w) get(d);
      if (!w) chk(d, e);
      if (inc) ofs += 16'h4;
    end
    if (w) rx_valid_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : xfer
  task automatic get(output logic [31:0] w);
    for (int n = 0; n < 400 && rq.size() < 4; n++) @(posedge ref_clk_in);
    if (rq.size() < 4) hang();
    for (int i = 0; i < 4; i++) w[8*i+:8] = rq.pop_front();
  endtask : get
  task automatic pkt_end();
    rx_end_in <= 1'b1;
    @(posedge ref_clk_in);
    rx_end_in <= 1'b0;
    for (int n = 0; n < 200 && unlock_active_out !== 1'b0; n++) @(posedge ref_clk_in);
    chk(32'(unlock_active_out), 32'h0);
    pend.delete();
    unl = 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask : pkt_end
  task automatic unlock(input logic [15:0] k);
    unlock_wr_in <= 1'b1;
    unlock_data_in <= k;
    @(posedge ref_clk_in);
    unlock_wr_in <= 1'b0;
    @(posedge ref_clk_in);
    unl = (k == 16'h5a03);
    chk(32'(unlock_active_out), 32'(unl));
  endtask : unlock
  // Main sequence
  initial
  begin
    logic [31:0] a;
    int p0;
    void'($urandom(28266));
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    xfer(0, 16'h0, 1, 1);
    $display("reset test done");
    a = {12'h0, 16'($urandom), 4'h0};
    slow <= 1'b1;
    unlock(16'h5a03);
    wq = {a, $urandom, $urandom, $urandom, $urandom};
    xfer(1, 16'h0, 1, 1);
    xfer(1, 16'h4, 3, 1);
    xfer(1, 16'h4, 1, 0);
    xfer(0, 16'h0, 1, 1);
    pkt_end();
    wq = {a};
    xfer(1, 16'h0, 1, 1);
    xfer(0, 16'h4, 2, 1);
    xfer(0, 16'h4, 3, 0);
    pkt_end();
    $display("program and read test done");
    unlock(16'h5a04);
    p0 = fia_fm_inst.progs;
    wq = {a + 32'h40, 32'h1, 32'h2, 32'h0};
    xfer(1, 16'h0, 1, 1);
    xfer(1, 16'h4, 2, 1);
    xfer(1, 16'hc, 1, 1);
    xfer(0, 16'h0, 1, 1);
    chk(32'(fia_fm_inst.progs - p0), 32'h0);
    pkt_end();
    unlock(16'h5a03);
    wq = {a + 32'h1000, 32'h0};
    xfer(1, 16'h0, 1, 1);
    xfer(1, 16'hc, 1, 1);
    xfer(0, 16'h0, 1, 1);
    chk(32'(fia_fm_inst.erases), 32'(eras));
    chk(fia_fm_inst.erase_at, era);
    pkt_end();
    $display("lock and erase test done");
    slow <= 1'b0;
    unlock(16'h5a03);
    wq = {a + 32'h80, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, a + 32'h80};
    xfer(1, 16'h0, 1, 1);
    xfer(1, 16'h4, 6, 1);
    xfer(0, 16'h4, 1, 1);
    xfer(1, 16'h0, 1, 1);
    xfer(0, 16'h4, 7, 1);
    pkt_end();
    $display("page limit test done");
    wq = {$urandom};
    xfer(0, 16'h8, 1, 1);
    xfer(1, 16'h8, 1, 1);
    xfer(0, 16'h8, 2, 0);
    xfer(0, 16'h8, 2, 1, 1);
    xfer(0, 16'hc, 1, 1);
    pkt_end();
    $display("identity test done");
    foreach (bad[i])
    begin
      err_seen <= 1'b0;
      put(bad[i][7:0]);
      put(bad[i][15:8]);
      put(8'h00);
      put(8'h00);
      rx_valid_in <= 1'b0;
      for (int n = 0; n < 20 && err_seen !== 1'b1; n++) @(posedge ref_clk_in);
      chk(32'(err_seen), 32'h1);
      pkt_end();
    end
    xfer(0, 16'h0, 1, 1);
    $display("bad command test done");
    finish_test();
  end
endmodule : flash_indirect_access_tb_top
